//--- hdl/gpm_pkg.sv
// register map, field layouts and state types of the masked gpio port
// shared by the port top and its pin synchroniser; no module logic here
package gpm_pkg;

  localparam int NPINS = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int SYNC_DEPTH = 3;

  // data window: every word in 0x000..0x3FC, mask taken from address 9:2
  localparam int MASK_LSB = 2;
  localparam int MASK_MSB = 9;
  localparam logic [ADDR_W-1:0] DATA_WIN_LAST = 12'h3FC;

  localparam logic [ADDR_W-1:0] OFF_DIRECTION = 12'h400;
  localparam logic [ADDR_W-1:0] OFF_SENSE = 12'h404;
  localparam logic [ADDR_W-1:0] OFF_DUAL_EDGE = 12'h408;
  localparam logic [ADDR_W-1:0] OFF_POLARITY = 12'h40C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h410;
  localparam logic [ADDR_W-1:0] OFF_RAW_STATUS = 12'h414;
  localparam logic [ADDR_W-1:0] OFF_MASKED_STATUS = 12'h418;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 12'h41C;
  localparam logic [ADDR_W-1:0] OFF_HW_SELECT = 12'h420;

  localparam logic [NPINS-1:0] RST_PIN_REG = 8'h00;
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [NPINS-1:0] out;
    logic [NPINS-1:0] oe;
  } gpm_hw_ctl_t;

  typedef struct packed {
    logic [NPINS-1:0] port_data_reg;
    logic [NPINS-1:0] direction_reg;
    logic [NPINS-1:0] detect_sense_reg;
    logic [NPINS-1:0] dual_edge_reg;
    logic [NPINS-1:0] event_polarity_reg;
    logic [NPINS-1:0] irq_mask_reg;
    logic [NPINS-1:0] hw_control_select_reg;
    logic [NPINS-1:0] edge_latch_reg;
    logic [NPINS-1:0] prev_pin_reg;
    logic [NPINS-1:0] raw_irq_status_reg;
    logic [NPINS-1:0] masked_irq_status_reg;
    logic [DATA_W-1:0] rdata_reg;
  } gpm_state_t;

  typedef struct packed {
    logic [SYNC_DEPTH-1:0] [NPINS-1:0] stage;
    logic [NPINS-1:0] stable;
  } gpm_sync_state_t;

endpackage

//--- hdl/gpm_pin_sync.sv
// three-stage synchroniser for the eight input pins
// assumes pins are asynchronous to CLK; a change counts once stages 1 and 2
// agree, which filters a single-cycle glitch at the cost of one more cycle
`timescale 1ns/1ps
module gpm_pin_sync (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [gpm_pkg::NPINS-1:0] PIN_RAW,
  output logic [gpm_pkg::NPINS-1:0] PIN_STABLE
);
  import gpm_pkg::*;

  gpm_sync_state_t state_reg;
  gpm_sync_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.stage[0] = PIN_RAW;
    // stage 0 feeds stage 1 only
    state_next.stage[1] = state_reg.stage[0];
    state_next.stage[2] = state_reg.stage[1];
    for (int i = 0; i < NPINS; i++) begin
      if (state_reg.stage[1][i] == state_reg.stage[2][i]) begin
        state_next.stable[i] = state_reg.stage[2][i];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign PIN_STABLE = state_reg.stable;

endmodule

//--- hdl/gpm_port.sv
// eight-line masked gpio port with per-pin interrupt detection, apb slave
// assumes an apb host on CLK, pins asynchronous, hw control from on chip
// Function
// - software mode drives written data bits onto pins set as outputs
// - data writes change only bits whose address mask bit is one
// - data reads return zero for bits whose address mask bit is zero
// - unmasked read gives written value for outputs, pin value for inputs
// - direction one makes output, zero input; reset leaves all inputs
// - sense bit one selects level detection, zero edge detection
// - dual-edge bit makes both edges trigger, else polarity decides
// - polarity one selects rising or high, zero falling or low
// - mask bit one lets detection raise its interrupt and combined line
// - raw status shows detected trigger conditions before masking
// - masked status is raw status gated by the mask bit
// - masked status bits are driven continuously on chip
// - reset clears all data, config and status registers
// - writing one to interrupt clear drops that pin's edge latch
// - hardware select bit hands the line to hardware control
`timescale 1ns/1ps
module gpm_port (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [gpm_pkg::ADDR_W-1:0] PADDR,
  input wire logic [gpm_pkg::DATA_W-1:0] PWDATA,
  output logic [gpm_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [gpm_pkg::NPINS-1:0] PIN_IN,
  output logic [gpm_pkg::NPINS-1:0] PIN_OUT,
  output logic [gpm_pkg::NPINS-1:0] PIN_OE,
  input wire gpm_pkg::gpm_hw_ctl_t HW_CTL,
  output logic [gpm_pkg::NPINS-1:0] MASKED_STATUS,
  output logic COMBINED_IRQ
);
  import gpm_pkg::*;

  gpm_state_t state_reg;
  gpm_state_t state_next;

  logic [NPINS-1:0] pin_in;
  logic [NPINS-1:0] rise;
  logic [NPINS-1:0] fall;
  logic [NPINS-1:0] edge_ev;
  logic [NPINS-1:0] level_hit;
  logic [NPINS-1:0] addr_mask;
  logic [NPINS-1:0] clear_bits;
  logic [NPINS-1:0] data_view;
  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  logic mapped;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic in_data_win(input logic [ADDR_W-1:0] a);
    in_data_win = (a <= DATA_WIN_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [NPINS-1:0] merge(input logic [NPINS-1:0] old_v,
                                             input logic [NPINS-1:0] new_v,
                                             input logic [NPINS-1:0] sel);
    merge = (old_v & ~sel) | (new_v & sel);
  endfunction

  gpm_pin_sync u_sync (
    .CLK(CLK),
    .RST(RST),
    .PIN_RAW(PIN_IN),
    .PIN_STABLE(pin_in)
  );

  assign setup_ph = PSEL && !PENABLE;
  assign access_ph = PSEL && PENABLE;
  assign wr_acc = access_ph && PWRITE;
  assign addr_mask = PADDR[MASK_MSB:MASK_LSB];
  // word-aligned register decode; unaligned offsets count as unmapped
  assign mapped = in_data_win(PADDR) || hit(PADDR, OFF_DIRECTION)
                  || hit(PADDR, OFF_SENSE) || hit(PADDR, OFF_DUAL_EDGE)
                  || hit(PADDR, OFF_POLARITY) || hit(PADDR, OFF_IRQ_MASK)
                  || hit(PADDR, OFF_RAW_STATUS)
                  || hit(PADDR, OFF_MASKED_STATUS)
                  || hit(PADDR, OFF_IRQ_CLEAR) || hit(PADDR, OFF_HW_SELECT);

  // pin view: written value for outputs, synchronised pin for inputs
  assign data_view = (state_reg.port_data_reg & state_reg.direction_reg)
                     | (pin_in & ~state_reg.direction_reg);

  assign rise = pin_in & ~state_reg.prev_pin_reg;
  assign fall = ~pin_in & state_reg.prev_pin_reg;
  // edge trigger only counts on edge-mode pins
  assign edge_ev = ~state_reg.detect_sense_reg
                   & ((state_reg.dual_edge_reg & (rise | fall))
                   | (~state_reg.dual_edge_reg
                   & ((state_reg.event_polarity_reg & rise)
                   | (~state_reg.event_polarity_reg & fall))));
  assign level_hit = (state_reg.event_polarity_reg & pin_in)
                     | (~state_reg.event_polarity_reg & ~pin_in);
  assign clear_bits = (wr_acc && hit(PADDR, OFF_IRQ_CLEAR)) ?
                      PWDATA[NPINS-1:0] : RST_PIN_REG;

  always_comb begin
    state_next = state_reg;
    state_next.prev_pin_reg = pin_in;
    if (wr_acc) begin
      if (in_data_win(PADDR)) begin
        state_next.port_data_reg = merge(state_reg.port_data_reg,
          PWDATA[NPINS-1:0], addr_mask);
      end
      if (hit(PADDR, OFF_DIRECTION)) begin
        state_next.direction_reg = PWDATA[NPINS-1:0];
      end
      if (hit(PADDR, OFF_SENSE)) begin
        state_next.detect_sense_reg = PWDATA[NPINS-1:0];
      end
      if (hit(PADDR, OFF_DUAL_EDGE)) begin
        state_next.dual_edge_reg = PWDATA[NPINS-1:0];
      end
      if (hit(PADDR, OFF_POLARITY)) begin
        state_next.event_polarity_reg = PWDATA[NPINS-1:0];
      end
      if (hit(PADDR, OFF_IRQ_MASK)) begin
        state_next.irq_mask_reg = PWDATA[NPINS-1:0];
      end
      if (hit(PADDR, OFF_HW_SELECT)) begin
        state_next.hw_control_select_reg = PWDATA[NPINS-1:0];
      end
    end
    // a new edge in the clearing cycle wins over the clear
    state_next.edge_latch_reg = (state_reg.edge_latch_reg & ~clear_bits)
                                | edge_ev;
    // level pins follow the pin, only edge pins latch
    state_next.raw_irq_status_reg =
      (state_next.detect_sense_reg & level_hit)
      | (~state_next.detect_sense_reg
      & state_next.edge_latch_reg);
    state_next.masked_irq_status_reg = state_next.raw_irq_status_reg
      & state_next.irq_mask_reg;
    // read data captured in setup so it is steady through access
    if (setup_ph && !PWRITE) begin
      state_next.rdata_reg = RST_WORD;
      if (in_data_win(PADDR)) begin
        state_next.rdata_reg[NPINS-1:0] = data_view & addr_mask;
      end else if (hit(PADDR, OFF_DIRECTION)) begin
        state_next.rdata_reg[NPINS-1:0] = state_reg.direction_reg;
      end else if (hit(PADDR, OFF_SENSE)) begin
        state_next.rdata_reg[NPINS-1:0] = state_reg.detect_sense_reg;
      end else if (hit(PADDR, OFF_DUAL_EDGE)) begin
        state_next.rdata_reg[NPINS-1:0] = state_reg.dual_edge_reg;
      end else if (hit(PADDR, OFF_POLARITY)) begin
        state_next.rdata_reg[NPINS-1:0] = state_reg.event_polarity_reg;
      end else if (hit(PADDR, OFF_IRQ_MASK)) begin
        state_next.rdata_reg[NPINS-1:0] = state_reg.irq_mask_reg;
      end else if (hit(PADDR, OFF_RAW_STATUS)) begin
        state_next.rdata_reg[NPINS-1:0] = state_reg.raw_irq_status_reg;
      end else if (hit(PADDR, OFF_MASKED_STATUS)) begin
        state_next.rdata_reg[NPINS-1:0] = state_reg.masked_irq_status_reg;
      end else if (hit(PADDR, OFF_HW_SELECT)) begin
        state_next.rdata_reg[NPINS-1:0] = state_reg.hw_control_select_reg;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign PRDATA = state_reg.rdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = access_ph && !mapped;
  // software mode drives data where direction says output
  assign PIN_OUT = merge(state_reg.port_data_reg, HW_CTL.out,
                         state_reg.hw_control_select_reg);
  assign PIN_OE = merge(state_reg.direction_reg, HW_CTL.oe,
                        state_reg.hw_control_select_reg);
  assign MASKED_STATUS = state_reg.masked_irq_status_reg;
  assign COMBINED_IRQ = |state_reg.masked_irq_status_reg;

  // helper for the read check below
  logic [NPINS-1:0] exp_read;
  assign exp_read = data_view & addr_mask;

  masked_write_a: assert property (
    @(posedge CLK) disable iff (RST)
    (wr_acc && in_data_win(PADDR)) |=>
      state_reg.port_data_reg == (($past(state_reg.port_data_reg)
      & ~$past(addr_mask)) | ($past(PWDATA[NPINS-1:0]) & $past(addr_mask))))
    else $error("masked data write changed wrong bits");

  data_read_a: assert property (
    @(posedge CLK) disable iff (RST)
    (setup_ph && !PWRITE && in_data_win(PADDR)) |=>
      PRDATA == {24'h000000, $past(exp_read)})
    else $error("data read does not match masked pin view");

  software_drive_a: assert property (
    @(posedge CLK) disable iff (RST)
    ((PIN_OUT & ~state_reg.hw_control_select_reg)
      == (state_reg.port_data_reg & ~state_reg.hw_control_select_reg))
    && ((PIN_OE & ~state_reg.hw_control_select_reg)
      == (state_reg.direction_reg & ~state_reg.hw_control_select_reg)))
    else $error("software pin drive wrong");

  hw_select_a: assert property (
    @(posedge CLK) disable iff (RST)
    ((PIN_OUT & state_reg.hw_control_select_reg)
      == (HW_CTL.out & state_reg.hw_control_select_reg))
    && ((PIN_OE & state_reg.hw_control_select_reg)
      == (HW_CTL.oe & state_reg.hw_control_select_reg)))
    else $error("hardware line not handed over");

  edge_hold_a: assert property (
    @(posedge CLK) disable iff (RST)
    (state_reg.edge_latch_reg != 8'h00 && clear_bits == 8'h00) |=>
      ((state_reg.edge_latch_reg & $past(state_reg.edge_latch_reg))
      == $past(state_reg.edge_latch_reg)))
    else $error("edge latch dropped without clear");

  edge_clear_a: assert property (
    @(posedge CLK) disable iff (RST)
    (clear_bits != 8'h00) |=>
      ((state_reg.edge_latch_reg & $past(clear_bits) & ~$past(edge_ev))
      == 8'h00))
    else $error("interrupt clear did not drop edge latch");

  dual_edge_a: assert property (
    @(posedge CLK) disable iff (RST)
    ((rise | fall) & ~state_reg.detect_sense_reg
      & state_reg.dual_edge_reg) != 8'h00 |=>
      ((state_reg.edge_latch_reg & $past(rise | fall)
      & $past(~state_reg.detect_sense_reg & state_reg.dual_edge_reg))
      == ($past(rise | fall)
      & $past(~state_reg.detect_sense_reg & state_reg.dual_edge_reg))))
    else $error("both-edge trigger missed");

  level_follow_a: assert property (
    @(posedge CLK) disable iff (RST)
    ##1 ((state_reg.raw_irq_status_reg & state_reg.detect_sense_reg)
      == ($past(level_hit) & state_reg.detect_sense_reg
      & $past(state_reg.detect_sense_reg))
      || $past(state_reg.detect_sense_reg) != state_reg.detect_sense_reg))
    else $error("level status does not follow the pin");

  combined_irq_a: assert property (
    @(posedge CLK) disable iff (RST)
    (COMBINED_IRQ == (MASKED_STATUS != 8'h00))
    && ((MASKED_STATUS & ~state_reg.irq_mask_reg) == 8'h00)
    && ((MASKED_STATUS & state_reg.irq_mask_reg)
      == (state_reg.raw_irq_status_reg & state_reg.irq_mask_reg)))
    else $error("masked status or combined irq wrong");

  reset_clear_a: assert property (
    @(posedge CLK)
    RST |=> (state_reg.port_data_reg == 8'h00
      && state_reg.direction_reg == 8'h00 && PIN_OE == 8'h00
      && state_reg.raw_irq_status_reg == 8'h00 && COMBINED_IRQ == 1'b0))
    else $error("reset left a register set");

  dir_write_a: assert property (
    @(posedge CLK) disable iff (RST)
    (wr_acc && hit(PADDR, OFF_DIRECTION)) |=>
      state_reg.direction_reg == $past(PWDATA[NPINS-1:0]))
    else $error("direction write not taken");

  sense_write_a: assert property (
    @(posedge CLK) disable iff (RST)
    (wr_acc && hit(PADDR, OFF_SENSE)) |=>
      state_reg.detect_sense_reg == $past(PWDATA[NPINS-1:0]))
    else $error("sense write not taken");

  dual_write_a: assert property (
    @(posedge CLK) disable iff (RST)
    (wr_acc && hit(PADDR, OFF_DUAL_EDGE)) |=>
      state_reg.dual_edge_reg == $past(PWDATA[NPINS-1:0]))
    else $error("dual-edge write not taken");

  polarity_write_a: assert property (
    @(posedge CLK) disable iff (RST)
    (wr_acc && hit(PADDR, OFF_POLARITY)) |=>
      state_reg.event_polarity_reg == $past(PWDATA[NPINS-1:0]))
    else $error("polarity write not taken");

  mask_write_a: assert property (
    @(posedge CLK) disable iff (RST)
    (wr_acc && hit(PADDR, OFF_IRQ_MASK)) |=>
      state_reg.irq_mask_reg == $past(PWDATA[NPINS-1:0]))
    else $error("mask write not taken");

  data_keep_a: assert property (
    @(posedge CLK) disable iff (RST)
    !(wr_acc && in_data_win(PADDR)) |=> $stable(state_reg.port_data_reg))
    else $error("data register changed without a data write");

  read_output_a: assert property (
    @(posedge CLK) disable iff (RST)
    (setup_ph && !PWRITE && in_data_win(PADDR)) |=>
      ((PRDATA[NPINS-1:0] ^ $past(state_reg.port_data_reg))
      & $past(state_reg.direction_reg & addr_mask)) == 8'h00)
    else $error("output pin read is not the written value");

  read_input_a: assert property (
    @(posedge CLK) disable iff (RST)
    (setup_ph && !PWRITE && in_data_win(PADDR)) |=>
      ((PRDATA[NPINS-1:0] ^ $past(pin_in))
      & $past(~state_reg.direction_reg & addr_mask)) == 8'h00)
    else $error("input pin read is not the pin level");

  read_upper_a: assert property (
    @(posedge CLK) disable iff (RST)
    PRDATA[DATA_W-1:NPINS] == 24'h000000)
    else $error("read data upper bits not zero");

  clear_read_a: assert property (
    @(posedge CLK) disable iff (RST)
    (setup_ph && !PWRITE && hit(PADDR, OFF_IRQ_CLEAR)) |=>
      PRDATA == RST_WORD)
    else $error("interrupt clear register is readable");

  // pins in single-edge mode, for the edge checks below
  logic [NPINS-1:0] single_edge;
  assign single_edge = ~state_reg.detect_sense_reg
                       & ~state_reg.dual_edge_reg;

  rise_edge_a: assert property (
    @(posedge CLK) disable iff (RST)
    (rise & single_edge & state_reg.event_polarity_reg) != 8'h00 |=>
      ((state_reg.edge_latch_reg
      & $past(rise & single_edge & state_reg.event_polarity_reg))
      == $past(rise & single_edge & state_reg.event_polarity_reg)))
    else $error("rising edge missed");

  fall_edge_a: assert property (
    @(posedge CLK) disable iff (RST)
    (fall & single_edge & ~state_reg.event_polarity_reg) != 8'h00 |=>
      ((state_reg.edge_latch_reg
      & $past(fall & single_edge & ~state_reg.event_polarity_reg))
      == $past(fall & single_edge & ~state_reg.event_polarity_reg)))
    else $error("falling edge missed");

  // level pins must never feed the edge latch, else a stale edge shows
  level_no_latch_a: assert property (
    @(posedge CLK) disable iff (RST)
    1'b1 |=> (state_reg.edge_latch_reg & $past(state_reg.detect_sense_reg
      & ~state_reg.edge_latch_reg)) == 8'h00)
    else $error("level pin latched an edge");

endmodule

//--- verif/gpm_pin_model.sv
// pad model for the eight port lines, one pad per line
// assumes the bench sets the outside level of every line at all times
`timescale 1ns/1ps
module gpm_pin_model (
  input wire logic [gpm_pkg::NPINS-1:0] PIN_OUT,
  input wire logic [gpm_pkg::NPINS-1:0] PIN_OE,
  input wire logic [gpm_pkg::NPINS-1:0] EXT,
  output logic [gpm_pkg::NPINS-1:0] PIN_IN
);
  import gpm_pkg::*;
  // a driven pad overrides the outside level
  assign PIN_IN = (PIN_OE & PIN_OUT) | (~PIN_OE & EXT);
endmodule

//--- verif/testbench.sv
// self-checking bench for the masked gpio port: bus, pins, interrupts
// assumes no wait states on the bus and a 10 MHz clock
`timescale 1ns/1ps
module testbench;
  import gpm_pkg::*;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [ADDR_W-1:0] PADDR = 12'h000;
  logic [DATA_W-1:0] PWDATA = 32'h0000_0000;
  logic [DATA_W-1:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic [NPINS-1:0] PIN_IN;
  logic [NPINS-1:0] PIN_OUT;
  logic [NPINS-1:0] PIN_OE;
  logic [NPINS-1:0] MASKED_STATUS;
  logic COMBINED_IRQ;
  logic [NPINS-1:0] ext = 8'h00;
  gpm_hw_ctl_t HW_CTL = 16'h0000;
  int miscompares = 0;
  int checks_done = 0;
  logic [7:0] data_exp, dir, m, d, sns, dual, pol, msk, a, b, latch, hsel;
  logic [31:0] rdv;
  logic err;

  always #50 CLK = ~CLK;

  gpm_port dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .PIN_OE(PIN_OE), .HW_CTL(HW_CTL), .MASKED_STATUS(MASKED_STATUS),
    .COMBINED_IRQ(COMBINED_IRQ));

  gpm_pin_model pins (.PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .EXT(ext),
    .PIN_IN(PIN_IN));

  task check(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task settle(input int n);
    repeat (n) @(posedge CLK);
    #5;
  endtask

  // request held from setup until the edge that samples ready high
  task apb(input logic wr, input logic [11:0] adr, input logic [7:0] wd);
    int n;
    n = 0;
    settle(1);
    PSEL = 1'b1;
    PENABLE = 1'b0;
    PWRITE = wr;
    PADDR = adr;
    PWDATA = {24'h000000, wd};
    settle(1);
    PENABLE = 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1 && n < 16) begin
      n++;
      @(posedge CLK);
    end
    rdv = PRDATA;
    err = PSLVERR;
    #5;
    PSEL = 1'b0;
    PENABLE = 1'b0;
  endtask

  task wr(input logic [11:0] adr, input logic [7:0] wd);
    apb(1'b1, adr, wd);
    check("write err", err, 1'b0);
  endtask

  task rd(input string name, input logic [11:0] adr, input logic [7:0] exp);
    apb(1'b0, adr, 8'h00);
    check(name, rdv, {24'h000000, exp});
    check("read err", err, 1'b0);
    check("read ready", PREADY, 1'b1);
  endtask

  function automatic logic [7:0] trig(input logic [7:0] o, n, bo, p);
    return (bo & (o ^ n)) | (~bo & p & ~o & n) | (~bo & ~p & o & ~n);
  endfunction

  task irq_chk(input logic [7:0] lv);
    logic [7:0] r;
    r = (sns & ~(pol ^ lv)) | (~sns & latch);
    rd("raw status", OFF_RAW_STATUS, r);
    rd("masked status", OFF_MASKED_STATUS, r & msk);
    check("status out", MASKED_STATUS, r & msk);
    check("combined irq", COMBINED_IRQ, |(r & msk));
  endtask

  initial begin
    repeat (20000) @(posedge CLK);
    miscompares++;
    results();
  end

  initial begin
    void'($urandom(1));
    settle(8);
    RST = 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd("reset reg", OFF_DIRECTION + 12'(4 * i), 8'h00);
    end
    rd("reset data", DATA_WIN_LAST, 8'h00);
    check("reset oe", PIN_OE, 8'h00);
    apb(1'b0, 12'h424, 8'h00);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rdv, 32'h0000_0000);
    wr(OFF_DIRECTION, 8'hFF);
    data_exp = 8'h00;
    for (int i = 0; i < 20; i++) begin
      m = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      d = 8'($urandom);
      wr(12'({m, 2'b00}), d);
      data_exp = (data_exp & ~m) | (d & m);
      check("pin out", PIN_OUT, data_exp);
      m = 8'($urandom);
      rd("data out", 12'({m, 2'b00}), data_exp & m);
    end
    for (int i = 0; i < 4; i++) begin
      dir = 8'($urandom);
      ext = 8'($urandom);
      wr(OFF_DIRECTION, dir);
      settle(6);
      check("pin oe", PIN_OE, dir);
      rd("data mix", DATA_WIN_LAST, (data_exp & dir) | (ext & ~dir));
    end
    hsel = 8'($urandom);
    HW_CTL = gpm_hw_ctl_t'(16'($urandom));
    wr(OFF_HW_SELECT, hsel);
    check("hw out", PIN_OUT, (hsel & HW_CTL.out) | (~hsel & data_exp));
    check("hw oe", PIN_OE, (hsel & HW_CTL.oe) | (~hsel & dir));
    rd("hw select", OFF_HW_SELECT, hsel);
    wr(OFF_HW_SELECT, 8'h00);
    wr(OFF_DIRECTION, 8'h00);
    // first rounds pure edge mode, the mode with the most state to get wrong
    for (int i = 0; i < 12; i++) begin
      sns = (i < 2) ? 8'h00 : 8'($urandom);
      dual = 8'($urandom);
      pol = 8'($urandom);
      msk = 8'($urandom);
      a = 8'($urandom);
      b = (i == 0) ? ~a : 8'($urandom);
      wr(OFF_SENSE, sns);
      wr(OFF_DUAL_EDGE, dual);
      wr(OFF_POLARITY, pol);
      wr(OFF_IRQ_MASK, msk);
      ext = a;
      settle(6);
      wr(OFF_IRQ_CLEAR, 8'hFF);
      // status is read only, so these writes must leave no trace
      wr(OFF_RAW_STATUS, 8'hFF);
      wr(OFF_MASKED_STATUS, 8'hFF);
      latch = 8'h00;
      irq_chk(a);
      ext = b;
      settle(6);
      latch = trig(a, b, dual, pol);
      irq_chk(b);
      ext = a;
      settle(6);
      latch |= trig(b, a, dual, pol);
      irq_chk(a);
      m = 8'($urandom);
      wr(OFF_IRQ_CLEAR, m);
      latch &= ~m;
      irq_chk(a);
      rd("clear reads zero", OFF_IRQ_CLEAR, 8'h00);
    end
    results();
  end
endmodule
